// *** design/byte_word_alu_ops.sv ***
// byte/word arithmetic, logic and shift datapath with an apb register slave
// assumes an apb3 master on clk_sys; one command runs at a time
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns

module byte_word_alu_ops
	import alu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ******************************
	// functions
	// ******************************
	function automatic logic [7:0] sel_byte(input logic [15:0] w, input logic lo);
		sel_byte = lo ? w[7:0] : w[15:8];
	endfunction : sel_byte

	function automatic logic [15:0] put_byte(input logic [15:0] w, input logic lo, input logic [7:0] b);
		put_byte = lo ? {w[15:8], b} : {b, w[7:0]};
	endfunction : put_byte

	function automatic logic is_zero8(input logic [7:0] b);
		is_zero8 = (b == 8'h00);
	endfunction : is_zero8

	// subtraction is a plus inverted b plus inverted borrow; carry out is inverted back to a borrow
	function automatic arith_t arith(input logic [15:0] a, input logic [15:0] b, input logic cin,
		input logic sub, input logic word);
		logic [15:0] bx;
		logic cx;
		logic [16:0] s16;
		logic [8:0] s8;
		logic [4:0] s4;
		logic [12:0] s12;
		bx = sub ? ~b : b;
		cx = sub ? ~cin : cin;
		s16 = {1'b0, a} + {1'b0, bx} + {16'h0000, cx};
		s8 = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cx};
		s4 = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
		s12 = {1'b0, a[11:0]} + {1'b0, bx[11:0]} + {12'h000, cx};
		arith.res = word ? s16[15:0] : {8'h00, s8[7:0]};
		arith.c = (word ? s16[16] : s8[8]) ^ sub;
		arith.h = (word ? s12[12] : s4[4]) ^ sub;
		arith.n = word ? s16[15] : s8[7];
		arith.z = word ? (s16[15:0] == 16'h0000) : is_zero8(s8[7:0]);
		arith.v = word ? ((a[15] == bx[15]) && (s16[15] != a[15])) : ((a[7] == bx[7]) && (s8[7] != a[7]));
	endfunction : arith

	// returns {carry, adjusted byte}
	function automatic logic [8:0] dec_adj(input logic [7:0] v, input logic c, input logic h, input logic sub);
		logic lo_fix;
		logic hi_fix;
		logic [7:0] adj;
		lo_fix = h | (~sub & (v[3:0] > BCD_DIGIT_MAX));
		hi_fix = c | (~sub & (v > BCD_BYTE_MAX));
		adj = {hi_fix ? BCD_FIX : 4'h0, lo_fix ? BCD_FIX : 4'h0};
		dec_adj = {hi_fix, sub ? v - adj : v + adj};
	endfunction : dec_adj

	// one-bit move; returns {overflow, carry, result}
	function automatic logic [9:0] shift1(input op_t op, input logic [7:0] v, input logic c);
		case (op)
			OP_ARITHMETIC_SHIFT_LEFT: shift1 = {v[7] ^ v[6], v[7], v[6:0], 1'b0};
			OP_LOGICAL_SHIFT_LEFT: shift1 = {1'b0, v[7], v[6:0], 1'b0};
			OP_ARITHMETIC_SHIFT_RIGHT: shift1 = {1'b0, v[0], v[7], v[7:1]};
			OP_LOGICAL_SHIFT_RIGHT: shift1 = {1'b0, v[0], 1'b0, v[7:1]};
			OP_ROTATE_LEFT: shift1 = {1'b0, v[7], v[6:0], v[7]};
			OP_ROTATE_RIGHT: shift1 = {1'b0, v[0], v[0], v[7:1]};
			OP_ROTATE_LEFT_THROUGH_CARRY: shift1 = {1'b0, v[7], v[6:0], c};
			OP_ROTATE_RIGHT_THROUGH_CARRY: shift1 = {1'b0, v[0], c, v[7:1]};
			default: shift1 = {1'b0, c, v};
		endcase
	endfunction : shift1

	function automatic logic imm_allowed(input op_t op);
		imm_allowed = (op == OP_ADD) || (op == OP_ADD_WITH_CARRY) || (op == OP_SUBTRACT_WITH_BORROW)
			|| (op == OP_CMP) || (op == OP_AND) || (op == OP_OR) || (op == OP_XOR);
	endfunction : imm_allowed

	function automatic logic cmd_illegal(input cmd_t c);
		cmd_illegal = (c.op > OP_ROTATE_RIGHT_THROUGH_CARRY) || (c.use_imm && !imm_allowed(c.op))
			|| (c.use_imm && c.word);
	endfunction : cmd_illegal

	// ******************************
	// state
	// ******************************
	state_t state_ff;
	state_t nxt_state;
	cmd_t cmd_ff;
	flags_t flags_ff;
	flags_t nxt_flags;
	logic illegal_ff;
	logic div_zero_ff;
	logic [1:0] gr_rd_ff;
	logic [31:0] prdata_ff;

	logic [15:0] rd_data_a;
	logic [15:0] rd_data_b;
	logic mem_wr_en;
	logic [15:0] res_word;
	logic res_wr;
	logic div_zero_now;

	// ******************************
	// apb decode
	// ******************************
	wire logic idle = (state_ff == ST_IDLE);
	wire logic exec = (state_ff == ST_EXEC);
	wire logic setup = psel & ~penable;
	wire logic access = psel & penable;
	wire logic hit_cmd = (paddr == OFS_CMD);
	wire logic hit_flags = (paddr == OFS_FLAGS);
	wire logic hit_status = (paddr == OFS_STATUS);
	wire logic hit_gr = (paddr[7:5] == OFS_GR_BASE[7:5]) && (paddr[1:0] == 2'h0);
	wire logic mapped = hit_cmd | hit_flags | hit_status | hit_gr;
	wire logic gr_read = hit_gr & ~pwrite;
	wire logic needs_idle = pwrite & (hit_cmd | hit_flags | hit_gr);
	wire logic done = access & pready;
	wire logic wr_ok = done & pwrite;
	wire cmd_t new_cmd = cmd_t'(pwdata);
	wire logic start = wr_ok & hit_cmd & ~cmd_illegal(new_cmd);
	wire logic [31:0] status_word = {29'h0000_0000, div_zero_ff, illegal_ff, ~idle};
	wire logic [31:0] rd_mux = hit_cmd ? cmd_ff :
		hit_flags ? {24'h00_0000, flags_ff} :
		hit_status ? status_word : 32'h0000_0000;

	// gr reads wait for the registered memory port; command, flags and gr writes wait out a running command
	assign pready = gr_read ? (gr_rd_ff == GR_RD_READY) : (~needs_idle | idle);
	assign pslverr = done & ~mapped;
	assign prdata = prdata_ff;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			gr_rd_ff <= GR_RD_IDLE;
		end else begin
			case (gr_rd_ff)
				GR_RD_IDLE: gr_rd_ff <= (access & gr_read & idle) ? GR_RD_FETCH : GR_RD_IDLE;
				GR_RD_FETCH: gr_rd_ff <= GR_RD_READY;
				default: gr_rd_ff <= access ? GR_RD_IDLE : gr_rd_ff;
			endcase
		end
	end

	// control registers are latched in setup so their reads complete with no wait state
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata_ff <= 32'h0000_0000;
		end else if (gr_rd_ff == GR_RD_FETCH) begin
			prdata_ff <= {16'h0000, rd_data_a};
		end else if (setup) begin
			prdata_ff <= rd_mux;
		end
	end

	// ******************************
	// command, status and flags
	// ******************************
	// an illegal command is kept for read-back but never started
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmd_ff <= cmd_t'(CMD_RESET);
			illegal_ff <= 1'b0;
		end else if (wr_ok & hit_cmd) begin
			cmd_ff <= new_cmd;
			illegal_ff <= cmd_illegal(new_cmd);
		end
	end

	// status bits 1 and 2 report the last command and clear on the next command write
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div_zero_ff <= 1'b0;
		end else if (exec) begin
			div_zero_ff <= div_zero_now;
		end else if (wr_ok & hit_cmd) begin
			div_zero_ff <= 1'b0;
		end
	end

	// software writes land only while idle, so they never meet an execute cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flags_ff <= flags_t'(FLAGS_RESET);
		end else if (exec) begin
			flags_ff <= nxt_flags;
		end else if (wr_ok & hit_flags) begin
			flags_ff <= flags_t'({3'h0, pwdata[4:0]});
		end
	end

	// ******************************
	// sequencer
	// ******************************
	// fetch lets the registered read ports settle on the command's operands
	always_comb begin
		case (state_ff)
			ST_IDLE: nxt_state = start ? ST_FETCH : ST_IDLE;
			ST_FETCH: nxt_state = ST_EXEC;
			ST_EXEC: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ******************************
	// general registers
	// ******************************
	// the bus owns the write port and read port a while idle; a running command owns them from fetch to execute; read port b always follows the command's source
	assign mem_wr_en = (exec & res_wr) | (wr_ok & hit_gr);
	wire logic [2:0] mem_addr = idle ? paddr[4:2] : cmd_ff.dst[2:0];
	wire logic [15:0] mem_wr_data = idle ? pwdata[15:0] : res_word;
	wire logic [2:0] mem_src_addr = cmd_ff.src[2:0];

	gr_mem u_gr_mem (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.wr_en(mem_wr_en),
		.wr_addr(mem_addr),
		.wr_data(mem_wr_data),
		.rd_addr_a(mem_addr),
		.rd_addr_b(mem_src_addr),
		.rd_data_a(rd_data_a),
		.rd_data_b(rd_data_b)
	);

	// ******************************
	// operand selection
	// ******************************
	wire op_t op = cmd_ff.op;
	wire logic dst_lo = cmd_ff.dst[3];
	wire logic [7:0] dst_b = sel_byte(rd_data_a, dst_lo);
	wire logic [7:0] src_b = cmd_ff.use_imm ? cmd_ff.imm : sel_byte(rd_data_b, cmd_ff.src[3]);
	wire logic small_op = (op == OP_WORD_ADD_SMALL_CONSTANT) || (op == OP_WORD_SUBTRACT_SMALL_CONSTANT);
	wire logic step_op = (op == OP_INC) || (op == OP_DEC);
	// the word bit counts only for add, subtract and compare; small constants are always word
	wire logic word_op = (cmd_ff.word && ((op == OP_ADD) || (op == OP_SUB) || (op == OP_CMP))) || small_op;
	wire logic ar_sub = (op == OP_SUB) || (op == OP_SUBTRACT_WITH_BORROW) || (op == OP_DEC)
		|| (op == OP_WORD_SUBTRACT_SMALL_CONSTANT) || (op == OP_CMP) || (op == OP_NEG);
	wire logic ar_cin = ((op == OP_ADD_WITH_CARRY) || (op == OP_SUBTRACT_WITH_BORROW)) & flags_ff.c;
	wire logic [15:0] ar_a = (op == OP_NEG) ? 16'h0000 : (word_op ? rd_data_a : {8'h00, dst_b});
	wire logic [15:0] ar_b = step_op ? SMALL_ONE :
		small_op ? (cmd_ff.two ? SMALL_TWO : SMALL_ONE) :
		(op == OP_NEG) ? {8'h00, dst_b} :
		word_op ? rd_data_b : {8'h00, src_b};
	wire arith_t ar = arith(ar_a, ar_b, ar_cin, ar_sub, word_op);
	wire logic [8:0] da = dec_adj(dst_b, flags_ff.c, flags_ff.h, op == OP_DECIMAL_ADJUST_AFTER_SUBTRACT);
	wire logic [9:0] sh = shift1(op, dst_b, flags_ff.c);
	wire logic [15:0] product = {8'h00, rd_data_a[7:0]} * {8'h00, src_b};
	wire logic divisor_zero = is_zero8(src_b);
	// a quotient wider than eight bits keeps only its low byte
	wire logic [15:0] quotient = divisor_zero ? 16'h0000 : rd_data_a / {8'h00, src_b};
	wire logic [15:0] remainder = divisor_zero ? 16'h0000 : rd_data_a % {8'h00, src_b};
	wire logic [7:0] logic_res = (op == OP_AND) ? (dst_b & src_b) :
		(op == OP_OR) ? (dst_b | src_b) :
		(op == OP_XOR) ? (dst_b ^ src_b) : ~dst_b;

	// ******************************
	// result and flags
	// ******************************
	always_comb begin
		res_word = rd_data_a;
		res_wr = 1'b0;
		nxt_flags = flags_ff;
		div_zero_now = 1'b0;
		case (op)
			OP_ADD, OP_SUB, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_CMP, OP_NEG: begin
				res_word = word_op ? ar.res : put_byte(rd_data_a, dst_lo, ar.res[7:0]);
				res_wr = (op != OP_CMP);
				nxt_flags.h = ar.h;
				nxt_flags.n = ar.n;
				nxt_flags.z = ar.z;
				nxt_flags.v = ar.v;
				nxt_flags.c = ar.c;
			end
			OP_INC, OP_DEC: begin
				res_word = put_byte(rd_data_a, dst_lo, ar.res[7:0]);
				res_wr = 1'b1;
				nxt_flags.n = ar.n;
				nxt_flags.z = ar.z;
				nxt_flags.v = ar.v;
			end
			OP_WORD_ADD_SMALL_CONSTANT, OP_WORD_SUBTRACT_SMALL_CONSTANT: begin
				res_word = ar.res;
				res_wr = 1'b1;
			end
			OP_DECIMAL_ADJUST_AFTER_ADD, OP_DECIMAL_ADJUST_AFTER_SUBTRACT: begin
				res_word = put_byte(rd_data_a, dst_lo, da[7:0]);
				res_wr = 1'b1;
				nxt_flags.n = da[7];
				nxt_flags.z = is_zero8(da[7:0]);
				nxt_flags.c = da[8];
			end
			OP_UNSIGNED_MULTIPLY: begin
				res_word = product;
				res_wr = 1'b1;
			end
			// a zero divisor leaves the destination untouched and raises the status bit
			OP_UNSIGNED_DIVIDE: begin
				res_word = {remainder[7:0], quotient[7:0]};
				res_wr = ~divisor_zero;
				div_zero_now = divisor_zero;
				nxt_flags.n = src_b[7];
				nxt_flags.z = divisor_zero;
			end
			OP_AND, OP_OR, OP_XOR, OP_NOT: begin
				res_word = put_byte(rd_data_a, dst_lo, logic_res);
				res_wr = 1'b1;
				nxt_flags.n = logic_res[7];
				nxt_flags.z = is_zero8(logic_res);
				nxt_flags.v = 1'b0;
			end
			OP_ARITHMETIC_SHIFT_LEFT, OP_ARITHMETIC_SHIFT_RIGHT, OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT,
			OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
				res_word = put_byte(rd_data_a, dst_lo, sh[7:0]);
				res_wr = 1'b1;
				nxt_flags.n = sh[7];
				nxt_flags.z = is_zero8(sh[7:0]);
				nxt_flags.v = sh[9];
				nxt_flags.c = sh[8];
			end
			default: begin
				res_wr = 1'b0;
			end
		endcase
	end

endmodule : byte_word_alu_ops

// *** design/alu_pkg.sv ***
// constants, types and command layout of the byte/word arithmetic datapath
// assumes one clock, software reaching the block over apb with 32-bit data
// Behaviour
// - add or subtract two general registers; add immediate byte to a register
// - no subtract-immediate form; such a command is refused
// - word add and subtract only between two general registers
// - byte add/subtract with carry, register or immediate source, plus carry flag
// - increment or decrement a byte register by one, written back
// - word register plus or minus one or two, written back
// - decimal adjust byte result to packed bcd from carry and half-carry flags
// - unsigned 8 by 8 multiply giving 16-bit product in destination word
// - unsigned 16 by 8 divide giving 8-bit quotient and remainder
// - compare subtracts and updates flags only, destination untouched
// - word compare only register to register; byte compare may use immediate
// - negate replaces byte register with zero minus its value
// - and, or, xor of byte register with register or immediate byte
// - not replaces byte register with its one's complement
// - arithmetic shifts of a byte register, right shift keeps sign bit
// - logical shifts of a byte register, vacated bit becomes zero
// - rotates of a byte register, leaving bit enters the other end
// - rotates through carry form a nine-bit ring with the carry flag
// - flags hold half-carry, negative, zero, overflow and carry, updated by operations

package alu_pkg;

	// ******************************
	// register map
	// ******************************
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_GR_BASE = 8'h20;
	localparam int GR_WORDS = 8;
	localparam logic [31:0] CMD_RESET = 32'h0000_0000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] GR_RESET = 16'h0000;
	localparam int STS_BUSY = 0;
	localparam int STS_ILLEGAL = 1;
	localparam int STS_DIV_ZERO = 2;
	localparam logic [1:0] GR_RD_IDLE = 2'h0;
	localparam logic [1:0] GR_RD_FETCH = 2'h1;
	localparam logic [1:0] GR_RD_READY = 2'h2;

	// ******************************
	// arithmetic constants
	// ******************************
	localparam logic [15:0] SMALL_ONE = 16'h0001;
	localparam logic [15:0] SMALL_TWO = 16'h0002;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
	localparam logic [3:0] BCD_FIX = 4'h6;

	// ******************************
	// operations
	// ******************************
	typedef enum logic [4:0] {
		OP_ADD = 5'h00,
		OP_SUB = 5'h01,
		OP_ADD_WITH_CARRY = 5'h02,
		OP_SUBTRACT_WITH_BORROW = 5'h03,
		OP_INC = 5'h04,
		OP_DEC = 5'h05,
		OP_WORD_ADD_SMALL_CONSTANT = 5'h06,
		OP_WORD_SUBTRACT_SMALL_CONSTANT = 5'h07,
		OP_DECIMAL_ADJUST_AFTER_ADD = 5'h08,
		OP_DECIMAL_ADJUST_AFTER_SUBTRACT = 5'h09,
		OP_UNSIGNED_MULTIPLY = 5'h0A,
		OP_UNSIGNED_DIVIDE = 5'h0B,
		OP_CMP = 5'h0C,
		OP_NEG = 5'h0D,
		OP_AND = 5'h0E,
		OP_OR = 5'h0F,
		OP_XOR = 5'h10,
		OP_NOT = 5'h11,
		OP_ARITHMETIC_SHIFT_LEFT = 5'h12,
		OP_ARITHMETIC_SHIFT_RIGHT = 5'h13,
		OP_LOGICAL_SHIFT_LEFT = 5'h14,
		OP_LOGICAL_SHIFT_RIGHT = 5'h15,
		OP_ROTATE_LEFT = 5'h16,
		OP_ROTATE_RIGHT = 5'h17,
		OP_ROTATE_LEFT_THROUGH_CARRY = 5'h18,
		OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h19
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_EXEC = 3'b100
	} state_t;

	// ******************************
	// carriers
	// ******************************
	// byte register index: bit 3 set selects the low byte of word [2:0]
	typedef struct packed {
		logic [5:0] rsvd_hi;
		logic two;
		logic use_imm;
		logic [7:0] imm;
		logic [3:0] src;
		logic [3:0] dst;
		logic word;
		logic [1:0] rsvd_lo;
		op_t op;
	} cmd_t;

	typedef struct packed {
		logic [2:0] rsvd;
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} flags_t;

	typedef struct packed {
		logic [15:0] res;
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} arith_t;

endpackage : alu_pkg

// *** design/gr_mem.sv ***
// eight 16-bit general registers, one write port and two registered read ports
// assumes writer and readers share clk_sys; read data lag the address by one edge
`timescale 1ns/1ns

module gr_mem
	import alu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [2:0] rd_addr_a,
	input wire logic [2:0] rd_addr_b,
	output logic [15:0] rd_data_a,
	output logic [15:0] rd_data_b
);

	logic [15:0] mem_ff [GR_WORDS];

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < GR_WORDS; i++) begin
				mem_ff[i] <= GR_RESET;
			end
		end else if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_a <= GR_RESET;
			rd_data_b <= GR_RESET;
		end else begin
			rd_data_a <= mem_ff[rd_addr_a];
			rd_data_b <= mem_ff[rd_addr_b];
		end
	end

endmodule : gr_mem

// *** sim/apb_host.sv ***
// apb master standing in for the cpu side that feeds the datapath
// assumes clk_sys is shared with the block; one transfer at a time
`timescale 1ns/1ns

module apb_host (
	input wire logic clk_sys,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	// ************************
	// transfer
	// ************************
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// request held until pready is seen high; answer taken at that edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic hung);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// pready, prdata and pslverr are read at the rising edge, before its updates land
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		hung = (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show the inverse, not a stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : apb_host

// *** sim/byte_word_alu_ops_asserts.sv ***
// port-level checks of the apb side of the datapath
// assumes it is bound to byte_word_alu_ops, one clock domain
`timescale 1ns/1ns

module byte_word_alu_ops_asserts
	import alu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ************************
	// checks
	// ************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic pen_ff;
	wire logic done;
	wire logic first;
	wire logic is_gr;
	wire logic is_ctl;
	assign done = psel && penable && pready;
	assign first = psel && penable && !pen_ff;
	assign is_gr = paddr >= OFS_GR_BASE && paddr < 8'h40 && paddr[1:0] == 2'h0;
	assign is_ctl = paddr == OFS_CMD || paddr == OFS_FLAGS || paddr == OFS_STATUS;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) pen_ff <= 1'b0;
		else pen_ff <= penable;
	end
	sequence gr_wait_s;
		!pready ##1 !pready;
	endsequence
	err_in_done_a: assert property (pslverr |-> done) else $error("pslverr outside completion");
	unmapped_err_a: assert property (done && !is_gr && !is_ctl |-> pslverr) else $error("no pslverr");
	mapped_ok_a: assert property (done && (is_gr || is_ctl) |-> !pslverr) else $error("stray pslverr");
	unmapped_zero_a: assert property (done && !pwrite && !is_gr && !is_ctl |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	flags_width_a: assert property (done && !pwrite && paddr == OFS_FLAGS |-> prdata[31:5] == 27'h0)
		else $error("flags upper bits set");
	gr_width_a: assert property (done && !pwrite && is_gr |-> prdata[31:16] == 16'h0000)
		else $error("register upper bits set");
	gr_wait_a: assert property (first && !pwrite && is_gr |-> gr_wait_s ##[1:4] pready)
		else $error("register read wait wrong");
	ctl_read_a: assert property (first && !pwrite && is_ctl |-> pready) else $error("control read waited");
	wr_done_a: assert property (first && pwrite |-> ##[0:3] pready) else $error("write not done");
endmodule : byte_word_alu_ops_asserts

bind byte_word_alu_ops byte_word_alu_ops_asserts byte_word_alu_ops_asserts_inst (.clk_sys(clk_sys),
	.arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** sim/tb_byte_word_alu_ops.sv ***
// self-checking bench for the byte/word datapath driven over apb
// assumes alu_pkg, the design and apb_host are compiled first
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_byte_word_alu_ops
	import alu_pkg::*;
	;
	// ************************
	// harness
	// ************************
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, err, hung;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int fail_count = 0;
	int total_checks = 0;
	always #10 clk_sys = ~clk_sys;
	byte_word_alu_ops byte_word_alu_ops_inst (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	apb_host apb_host_inst (.clk_sys(clk_sys), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	task automatic close_out;
		if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb_host_inst.xfer(w, a, d, q, err, hung);
		if (hung) begin
			fail_count++;
			close_out();
		end
	endtask : bus
	function automatic logic [7:0] gra(input int i);
		return OFS_GR_BASE + 8'(4 * i);
	endfunction : gra
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, q)
	endtask : rd
	task automatic gs(input int i, input logic [15:0] v);
		bus(1'b1, gra(i), {16'h0000, v});
	endtask : gs
	task automatic flg(input logic [31:0] v);
		bus(1'b1, OFS_FLAGS, v);
	endtask : flg
	task automatic run(input op_t op, input logic [3:0] dst, input logic [3:0] src, input logic wd = 1'b0,
		input logic ui = 1'b0, input logic [7:0] imm = 8'h00, input logic tw = 1'b0);
		cmd_t c;
		int n;
		c = '{6'h00, tw, ui, imm, src, dst, wd, 2'h0, op};
		bus(1'b1, OFS_CMD, 32'(c));
		// flags read during execute would show the old value; wait out busy first
		n = 0;
		bus(1'b0, OFS_STATUS, 32'h0000_0000);
		while (q[STS_BUSY] !== 1'b0 && n < 8) begin
			n++;
			bus(1'b0, OFS_STATUS, 32'h0000_0000);
		end
		if (q[STS_BUSY] !== 1'b0) begin
			fail_count++;
			close_out();
		end
	endtask : run

	// ************************
	// scenarios
	// ************************
	task automatic t_apb;
		rd("cmd", OFS_CMD, 32'h0);
		rd("sts", OFS_STATUS, 32'h0);
		rd("r0", gra(0), 32'h0);
		bus(1'b0, 8'h44, 32'h0);
		`CHK("rderr", 1'b1, err)
		`CHK("rdq", 32'h0, q)
		bus(1'b1, 8'h10, 32'hFFFF_FFFF);
		`CHK("wrerr", 1'b1, err)
		bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		rd("sts", OFS_STATUS, 32'h0);
		flg(32'hFFFF_FFFF);
		rd("flg", OFS_FLAGS, 32'h1F);
	endtask : t_apb
	task automatic t_add;
		gs(1, 16'h007F);
		gs(2, 16'h0001);
		run(OP_ADD, 4'h9, 4'hA);
		rd("r1", gra(1), 32'h80);
		rd("flg", OFS_FLAGS, 32'h1A);
		run(OP_ADD, 4'h9, 4'h0, 1'b0, 1'b1, 8'h80);
		rd("r1", gra(1), 32'h0);
		rd("flg", OFS_FLAGS, 32'h07);
		run(OP_SUB, 4'h9, 4'h0, 1'b0, 1'b1, 8'h01);
		rd("r1", gra(1), 32'h0);
		rd("sts", OFS_STATUS, 32'h2);
		run(OP_ADD, 4'h1, 4'h0, 1'b1, 1'b1, 8'h01);
		rd("sts", OFS_STATUS, 32'h2);
		gs(3, 16'h0FFF);
		gs(4, 16'h0001);
		run(OP_ADD, 4'h3, 4'h4, 1'b1);
		rd("r3", gra(3), 32'h1000);
		rd("flg", OFS_FLAGS, 32'h10);
		rd("sts", OFS_STATUS, 32'h0);
	endtask : t_add
	task automatic t_carry;
		gs(5, 16'h0010);
		flg(32'h1);
		run(OP_ADD_WITH_CARRY, 4'hD, 4'h0, 1'b0, 1'b1, 8'h05);
		rd("r5", gra(5), 32'h16);
		flg(32'h1);
		run(OP_SUBTRACT_WITH_BORROW, 4'hD, 4'hA);
		rd("r5", gra(5), 32'h14);
		rd("flg", OFS_FLAGS, 32'h0);
	endtask : t_carry
	task automatic t_incdec;
		gs(6, 16'h7F00);
		flg(32'h0);
		run(OP_INC, 4'h6, 4'h0);
		rd("r6", gra(6), 32'h8000);
		rd("flg", OFS_FLAGS, 32'h0A);
		run(OP_DEC, 4'h6, 4'h0);
		rd("r6", gra(6), 32'h7F00);
		rd("flg", OFS_FLAGS, 32'h02);
	endtask : t_incdec
	task automatic t_small;
		gs(7, 16'hFFFF);
		flg(32'h1F);
		run(OP_WORD_ADD_SMALL_CONSTANT, 4'h7, 4'h0);
		rd("r7", gra(7), 32'h0);
		run(OP_WORD_ADD_SMALL_CONSTANT, 4'h7, 4'h0, 1'b0, 1'b0, 8'h00, 1'b1);
		rd("r7", gra(7), 32'h2);
		run(OP_WORD_SUBTRACT_SMALL_CONSTANT, 4'h7, 4'h0, 1'b0, 1'b0, 8'h00, 1'b1);
		rd("r7", gra(7), 32'h0);
		rd("flg", OFS_FLAGS, 32'h1F);
	endtask : t_small
	task automatic t_bcd;
		gs(0, 16'h0019);
		gs(1, 16'h0028);
		run(OP_ADD, 4'h8, 4'h9);
		run(OP_DECIMAL_ADJUST_AFTER_ADD, 4'h8, 4'h0);
		rd("r0", gra(0), 32'h47);
		rd("flg", OFS_FLAGS, 32'h10);
		gs(0, 16'h0041);
		gs(1, 16'h0019);
		run(OP_SUB, 4'h8, 4'h9);
		run(OP_DECIMAL_ADJUST_AFTER_SUBTRACT, 4'h8, 4'h0);
		rd("r0", gra(0), 32'h22);
	endtask : t_bcd
	task automatic t_muldiv;
		gs(0, 16'h00C8);
		gs(1, 16'h0003);
		run(OP_UNSIGNED_MULTIPLY, 4'h8, 4'h9);
		rd("r0", gra(0), 32'h0258);
		gs(2, 16'h0259);
		run(OP_UNSIGNED_DIVIDE, 4'hA, 4'h9);
		rd("r2", gra(2), 32'h01C8);
		gs(3, 16'h0000);
		run(OP_UNSIGNED_DIVIDE, 4'hA, 4'hB);
		rd("r2", gra(2), 32'h01C8);
		rd("sts", OFS_STATUS, 32'h4);
	endtask : t_muldiv
	task automatic t_cmp;
		gs(4, 16'h0005);
		gs(5, 16'h0006);
		run(OP_CMP, 4'hC, 4'h0, 1'b0, 1'b1, 8'h05);
		rd("flg", OFS_FLAGS, 32'h04);
		run(OP_CMP, 4'h4, 4'h5, 1'b1);
		rd("r4", gra(4), 32'h5);
		rd("flg", OFS_FLAGS, 32'h19);
		run(OP_CMP, 4'h4, 4'h0, 1'b1, 1'b1, 8'h05);
		rd("sts", OFS_STATUS, 32'h2);
		gs(5, 16'h0001);
		run(OP_NEG, 4'hD, 4'h0);
		rd("r5", gra(5), 32'hFF);
		rd("flg", OFS_FLAGS, 32'h19);
	endtask : t_cmp
	task automatic t_logic;
		op_t lop[3] = '{OP_AND, OP_OR, OP_XOR};
		logic [31:0] lres[3] = '{32'h88, 32'hEE, 32'h66};
		logic [31:0] lfl[3] = '{32'h09, 32'h09, 32'h01};
		for (int i = 0; i < 3; i++) begin
			gs(6, 16'h00CC);
			flg(32'h1);
			run(lop[i], 4'hE, 4'h0, 1'b0, 1'b1, 8'hAA);
			rd("r6", gra(6), lres[i]);
			rd("flg", OFS_FLAGS, lfl[i]);
		end
		run(OP_NOT, 4'hE, 4'h0);
		rd("r6", gra(6), 32'h99);
	endtask : t_logic
	task automatic t_shift;
		logic [31:0] sres[8] = '{32'h02, 32'hC0, 32'h02, 32'h40, 32'h03, 32'hC0, 32'h02, 32'h40};
		for (int i = 0; i < 8; i++) begin
			gs(7, 16'h0081);
			flg(32'h0);
			run(op_t'(5'h12 + 5'(i)), 4'hF, 4'h0);
			rd("r7", gra(7), sres[i]);
			bus(1'b0, OFS_FLAGS, 32'h0);
			`CHK("c", 1'b1, q[0])
		end
	endtask : t_shift

	initial begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_apb();
		t_add();
		t_carry();
		t_incdec();
		t_small();
		t_bcd();
		t_muldiv();
		t_cmp();
		t_logic();
		t_shift();
		close_out();
	end
endmodule : tb_byte_word_alu_ops
